/* pmc_power_mode_controller.sv */
// Power mode controller: idle, power-down, wake-up and pin conditions
`default_nettype none
// Behaviour
// - Idle entered after setting instruction; CPU halts
// - Idle gates CPU clock, peripheral clock runs
// - Idle keeps PC, status, registers, RAM
// - Both bits set: power-down only, no idle
// - Enabled interrupt clears idle, restores CPU clock
// - Reset pin clears request bits, restores clocks
// - Block RAM during resumed execution before reset
// - Power-down stops oscillator, freezes all clocks
// - Power-down entered after setting instruction completes
// - Only external interrupt or reset exits power-down
// - Resume only after wake input released
// - Interrupt wake leaves registers and RAM intact
// - Reset wake reinitialises registers, keeps RAM
// - Reset floats low port, drives others high
// - Idle holds ports, strobes high, float external
// - Power-down holds ports, strobes low, float external
module pmc_power_mode_controller (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic reset_pin_in,
  input wire logic instr_done_in,
  input wire logic power_control_reg_we_in,
  input wire logic [3:0] power_control_reg_wdata_in,
  input wire logic irq_pending_in,
  input wire logic ext_irq0_n_in,
  input wire logic ext_irq1_n_in,
  input wire logic ext_irq0_en_in,
  input wire logic ext_irq1_en_in,
  input wire logic ext_code_in,
  input wire logic osc_stable_in,
  input wire logic [7:0] port0_data_in,
  input wire logic [7:0] port1_data_in,
  input wire logic [7:0] port2_data_in,
  input wire logic [7:0] port3_data_in,
  input wire logic ale_run_in,
  input wire logic program_store_strobe_n_run_in,
  output logic [3:0] power_control_reg_out,
  output logic cpu_clk_en_out,
  output logic periph_clk_en_out,
  output logic osc_en_out,
  output logic cpu_hold_out,
  output logic sfr_reset_out,
  output logic [15:0] reset_vector_out,
  output logic ram_block_out,
  output logic [1:0] mode_out,
  output logic [7:0] port0_out,
  output logic [7:0] port0_oe_n_out,
  output logic [7:0] port1_out,
  output logic [7:0] port2_out,
  output logic [7:0] port3_out,
  output logic ale_out,
  output logic program_store_strobe_n_out
);
  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    pmc_pkg::pmc_mode_type mode;
    logic [3:0] power_control_reg;
    logic [3:0] resume_cnt;
    logic resuming;
    logic [7:0] p0;
    logic [7:0] p1;
    logic [7:0] p2;
    logic [7:0] p3;
  } pmc_state_type;
  pmc_state_type state;
  pmc_state_type next_state;
  logic reset_sync;
  logic irq0_sync;
  logic irq1_sync;
  logic wake_level;
  logic pd_wake_async;
  logic reset_async;
  logic ext_wake_sync;

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  // Cleared by internal reset, so a pin level left over from reset cannot reopen the resume window
  pmc_sync #(.RESET_VAL(1'b0)) u_sync_rst (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .d_in(reset_pin_in),
    .q_out(reset_sync)
  );
  pmc_sync #(.RESET_VAL(1'b1)) u_sync_irq0 (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .d_in(ext_irq0_n_in),
    .q_out(irq0_sync)
  );
  pmc_sync #(.RESET_VAL(1'b1)) u_sync_irq1 (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .d_in(ext_irq1_n_in),
    .q_out(irq1_sync)
  );

  // ----------------------------------------
  // Asynchronous wake paths and synchronised wake level
  // ----------------------------------------
  // clockless wake detect
  // Oscillator may be stopped, so raw pins gate the enables directly
  assign pd_wake_async = (ext_irq0_en_in & ~ext_irq0_n_in) | (ext_irq1_en_in & ~ext_irq1_n_in);
  assign reset_async = reset_pin_in;
  assign ext_wake_sync = (ext_irq0_en_in & ~irq0_sync) | (ext_irq1_en_in & ~irq1_sync);
  assign wake_level = ext_wake_sync;

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    next_state = state;
    // Port latches follow CPU only while it runs
    if (state.mode == pmc_pkg::PMC_RUN) begin
      next_state.p0 = port0_data_in;
      next_state.p1 = port1_data_in;
      next_state.p2 = port2_data_in;
      next_state.p3 = port3_data_in;
    end
    // Software write of the power control register
    if (power_control_reg_we_in && state.mode == pmc_pkg::PMC_RUN) begin
      next_state.power_control_reg = power_control_reg_wdata_in;
    end
    // Resume window countdown ahead of internal reset
    if (state.resuming && state.resume_cnt != 4'h0) begin
      next_state.resume_cnt = state.resume_cnt - 4'h1;
    end
    case (state.mode)
      pmc_pkg::PMC_RUN: begin
        if (instr_done_in && state.power_control_reg[pmc_pkg::PDOWN_BIT]) begin
          next_state.mode = pmc_pkg::PMC_PDOWN;
        end else if (instr_done_in && state.power_control_reg[pmc_pkg::IDLE_BIT]) begin
          next_state.mode = pmc_pkg::PMC_IDLE;
        end
      end
      pmc_pkg::PMC_IDLE: begin
        if (irq_pending_in) begin
          next_state.power_control_reg[pmc_pkg::IDLE_BIT] = 1'b0;
          next_state.mode = pmc_pkg::PMC_RUN;
        end
      end
      pmc_pkg::PMC_PDOWN: begin
        if (wake_level) begin
          // idle bit dropped too so no fall into idle
          next_state.power_control_reg[pmc_pkg::PDOWN_BIT] = 1'b0;
          next_state.power_control_reg[pmc_pkg::IDLE_BIT] = 1'b0;
          next_state.mode = pmc_pkg::PMC_WAKE;
        end
      end
      pmc_pkg::PMC_WAKE: begin
        if (!wake_level && osc_stable_in) begin
          next_state.mode = pmc_pkg::PMC_RUN;
        end
      end
      default: begin
        next_state.mode = pmc_pkg::PMC_RUN;
      end
    endcase
    if (reset_sync && !state.resuming) begin
      next_state.resuming = 1'b1;
      next_state.resume_cnt = pmc_pkg::RESUME_CYCLES;
      next_state.power_control_reg[pmc_pkg::IDLE_BIT] = 1'b0;
      next_state.power_control_reg[pmc_pkg::PDOWN_BIT] = 1'b0;
      next_state.mode = pmc_pkg::PMC_RUN;
    end else if (!reset_sync) begin
      next_state.resuming = 1'b0;
    end
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  // reset reinitialises control bits; RAM untouched here
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      state.mode <= pmc_pkg::PMC_RUN;
      state.power_control_reg <= pmc_pkg::POWER_CONTROL_REG_RESET;
      state.resume_cnt <= 4'h0;
      state.resuming <= 1'b0;
      state.p0 <= pmc_pkg::PORT_HIGH;
      state.p1 <= pmc_pkg::PORT_HIGH;
      state.p2 <= pmc_pkg::PORT_HIGH;
      state.p3 <= pmc_pkg::PORT_HIGH;
    end else begin
      state <= next_state;
    end
  end

  // ----------------------------------------
  // Clock and core control
  // ----------------------------------------
  // CPU clock gated in idle and while held
  // reset pin restores clocks at once
  assign cpu_clk_en_out = reset_async | (state.mode == pmc_pkg::PMC_RUN);
  // raw wake restores oscillator and peripheral clock
  assign osc_en_out = reset_async | pd_wake_async | (state.mode != pmc_pkg::PMC_PDOWN);
  assign periph_clk_en_out = reset_async | pd_wake_async |
                             (state.mode == pmc_pkg::PMC_RUN) | (state.mode == pmc_pkg::PMC_IDLE);
  // no execution until wake input released
  assign cpu_hold_out = (state.mode != pmc_pkg::PMC_RUN);
  // registers reset once resume window ends
  assign sfr_reset_out = rst_in | (state.resuming && state.resume_cnt == 4'h0);
  assign reset_vector_out = pmc_pkg::RESET_VECTOR;
  assign ram_block_out = state.resuming;
  assign mode_out = state.mode;
  assign power_control_reg_out = state.power_control_reg;

  // ----------------------------------------
  // Pin conditions
  // ----------------------------------------
  // Drive-low enables; floating means all enables high
  always_comb begin
    port0_out = state.p0;
    port0_oe_n_out = 8'h00;
    port1_out = state.p1;
    port2_out = state.p2;
    port3_out = state.p3;
    ale_out = ale_run_in;
    program_store_strobe_n_out = program_store_strobe_n_run_in;
    if (rst_in) begin
      // reset floats low port, others high
      port0_oe_n_out = pmc_pkg::PORT_HIGH;
      port1_out = pmc_pkg::PORT_HIGH;
      port2_out = pmc_pkg::PORT_HIGH;
      port3_out = pmc_pkg::PORT_HIGH;
      ale_out = 1'b1;
      program_store_strobe_n_out = 1'b1;
    end else if (state.mode == pmc_pkg::PMC_IDLE) begin
      ale_out = 1'b1;
      program_store_strobe_n_out = 1'b1;
      if (ext_code_in) begin
        port0_oe_n_out = pmc_pkg::PORT_HIGH;
      end
    end else if (state.mode == pmc_pkg::PMC_PDOWN || state.mode == pmc_pkg::PMC_WAKE) begin
      ale_out = 1'b0;
      program_store_strobe_n_out = 1'b0;
      if (ext_code_in) begin
        port0_oe_n_out = pmc_pkg::PORT_HIGH;
      end
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  a_idle_entry: assert property (state.mode == pmc_pkg::PMC_RUN && instr_done_in && !reset_sync &&
      state.power_control_reg[pmc_pkg::IDLE_BIT] && !state.power_control_reg[pmc_pkg::PDOWN_BIT] |=> state.mode == pmc_pkg::PMC_IDLE)
    else $error("idle not entered");
  a_idle_cpu_clk: assert property (state.mode == pmc_pkg::PMC_IDLE && !reset_pin_in |->
      !cpu_clk_en_out && periph_clk_en_out)
    else $error("idle clock gating wrong");
  a_pd_priority: assert property (state.mode == pmc_pkg::PMC_RUN && instr_done_in && !reset_sync &&
      state.power_control_reg[pmc_pkg::PDOWN_BIT] |=> state.mode == pmc_pkg::PMC_PDOWN)
    else $error("power-down lost precedence");
  a_idle_exit: assert property (state.mode == pmc_pkg::PMC_IDLE && irq_pending_in && !reset_sync |=>
      state.mode == pmc_pkg::PMC_RUN && !state.power_control_reg[pmc_pkg::IDLE_BIT])
    else $error("idle exit failed");
  a_reset_clear: assert property (reset_sync && !state.resuming |=>
      !state.power_control_reg[pmc_pkg::IDLE_BIT] && !state.power_control_reg[pmc_pkg::PDOWN_BIT])
    else $error("reset did not clear requests");
  a_ram_block: assert property ($rose(state.resuming) |-> ram_block_out [*4])
    else $error("RAM not blocked on resume");
  a_pd_osc_off: assert property (state.mode == pmc_pkg::PMC_PDOWN && !pd_wake_async && !reset_pin_in |->
      !osc_en_out && !cpu_clk_en_out && !periph_clk_en_out)
    else $error("clocks run in power-down");
  a_pd_exit: assert property (state.mode == pmc_pkg::PMC_PDOWN && !wake_level && !reset_sync |=>
      state.mode == pmc_pkg::PMC_PDOWN)
    else $error("power-down left without cause");
  a_wake_hold: assert property (state.mode == pmc_pkg::PMC_WAKE && wake_level |-> cpu_hold_out)
    else $error("execution resumed early");
  a_pd_strobes: assert property (state.mode == pmc_pkg::PMC_PDOWN |->
      !ale_out && !program_store_strobe_n_out)
    else $error("power-down strobes not low");
  a_idle_strobes: assert property (state.mode == pmc_pkg::PMC_IDLE |->
      ale_out && program_store_strobe_n_out && (port0_oe_n_out == pmc_pkg::PORT_HIGH) == ext_code_in)
    else $error("idle pin condition wrong");

  // ----------------------------------------
  // Wake and resume assertions
  // ----------------------------------------
  // Wake paths are the real hazard: a missed clear strands the core asleep
  a_wake_clear: assert property (state.mode == pmc_pkg::PMC_PDOWN && wake_level && !reset_sync |=>
      state.mode == pmc_pkg::PMC_WAKE && !state.power_control_reg[pmc_pkg::PDOWN_BIT])
    else $error("power-down wake did not clear request");
  a_no_idle_fall: assert property (state.mode == pmc_pkg::PMC_WAKE |->
      !state.power_control_reg[pmc_pkg::IDLE_BIT] && !state.power_control_reg[pmc_pkg::PDOWN_BIT])
    else $error("request bits left set after wake");
  a_wake_resume: assert property (state.mode == pmc_pkg::PMC_WAKE && !wake_level && osc_stable_in &&
      !reset_sync |=> state.mode == pmc_pkg::PMC_RUN)
    else $error("execution did not resume after release");
  a_osc_restart: assert property (state.mode == pmc_pkg::PMC_PDOWN && pd_wake_async |->
      osc_en_out && periph_clk_en_out)
    else $error("oscillator not restarted by wake pin");
  a_reset_clocks: assert property (reset_pin_in |-> cpu_clk_en_out && periph_clk_en_out && osc_en_out)
    else $error("reset pin did not restore clocks");
  a_sfr_reset: assert property (state.resuming && state.resume_cnt == 4'h1 && reset_sync |=>
      sfr_reset_out)
    else $error("internal reset did not follow resume window");

  // ----------------------------------------
  // Idle and pin assertions
  // ----------------------------------------
  a_idle_hold: assert property (state.mode == pmc_pkg::PMC_IDLE |-> cpu_hold_out)
    else $error("core not held in idle");
  a_idle_frozen: assert property (state.mode == pmc_pkg::PMC_IDLE |=>
      $stable({port0_out, port1_out, port2_out, port3_out}))
    else $error("port latches moved in idle");
  a_pd_p0_float: assert property (state.mode == pmc_pkg::PMC_PDOWN && ext_code_in |->
      port0_oe_n_out == pmc_pkg::PORT_HIGH)
    else $error("low port driven in power-down");
  a_wake_strobes: assert property (state.mode == pmc_pkg::PMC_WAKE |->
      !ale_out && !program_store_strobe_n_out)
    else $error("strobes rose before resume");

  c_idle_round: cover property (state.mode == pmc_pkg::PMC_IDLE ##1 state.mode == pmc_pkg::PMC_RUN);
  c_pd_wake: cover property (state.mode == pmc_pkg::PMC_WAKE ##[1:20] state.mode == pmc_pkg::PMC_RUN);
  c_reset_exit: cover property (state.mode == pmc_pkg::PMC_PDOWN ##1 state.resuming);
  c_irq1_wake: cover property (state.mode == pmc_pkg::PMC_PDOWN && ext_irq1_en_in && !irq1_sync);
  c_resume_end: cover property (state.resuming && state.resume_cnt == 4'h0);
endmodule
`default_nettype wire

/* pmc_pkg.sv */
// Package of constants and types for the power mode controller
`default_nettype none
package pmc_pkg;
  // Power control register bit positions (layout of power_control_reg)
  localparam int IDLE_BIT = 0;
  localparam int PDOWN_BIT = 1;
  localparam int GF0_BIT = 2;
  localparam int GF1_BIT = 3;
  localparam int POWER_CONTROL_REG_W = 4;
  localparam logic [3:0] POWER_CONTROL_REG_RESET = 4'h0;
  // Reset vector of the CPU
  localparam logic [15:0] RESET_VECTOR = 16'h0000;
  // Port widths
  localparam int PORT_W = 8;
  localparam int NUM_PORTS = 4;
  localparam logic [7:0] PORT_HIGH = 8'hFF;
  // Cycles that resumed execution may run before internal reset
  localparam logic [3:0] RESUME_CYCLES = 4'h4;
  // Operating modes
  typedef enum logic [1:0] {
    PMC_RUN = 2'b00,
    PMC_IDLE = 2'b01,
    PMC_PDOWN = 2'b10,
    PMC_WAKE = 2'b11
  } pmc_mode_type;
endpackage
`default_nettype wire

/* pmc_sync.sv */
// Two-flop synchroniser for pin levels
`default_nettype none
module pmc_sync #(
  parameter logic RESET_VAL = 1'b0
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic d_in,
  output logic q_out
);
  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic s1;
    logic s2;
  } pmc_sync_state_type;
  pmc_sync_state_type state;
  pmc_sync_state_type next_state;
  // Shift the pin level through two stages
  always_comb begin
    next_state.s1 = d_in;
    next_state.s2 = state.s1;
  end
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      state <= {RESET_VAL, RESET_VAL};
    end else begin
      state <= next_state;
    end
  end
  assign q_out = state.s2;
endmodule
`default_nettype wire

/* pmc_osc_model.sv */
// Behavioural oscillator model standing beside the power mode controller
`default_nettype none
module pmc_osc_model #(
  parameter int START_CYCLES = 5
) (
  input wire logic clk_in,
  input wire logic osc_en_in,
  output logic osc_stable_out
);
  timeunit 1ns;
  timeprecision 1ps;
  int count = 0;
  // ----------------------------------------
  // Start-up delay
  // ----------------------------------------
  // stopped oscillator loses stability
  // Stability drops at once when stopped, so a design that resumes early is caught
  always @(posedge clk_in) begin
    if (!osc_en_in) begin
      count <= 0;
    end else if (count < START_CYCLES) begin
      count <= count + 1;
    end
  end
  assign osc_stable_out = osc_en_in && (count >= START_CYCLES);
endmodule
`default_nettype wire

/* pmc_power_mode_controller_tb_top.sv */
// Self-checking testbench of the power mode controller
`default_nettype none
module pmc_power_mode_controller_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_in = 0, rst_in = 1, reset_pin_in = 0, instr_done_in = 0, power_control_reg_we_in = 0;
  logic [3:0] power_control_reg_wdata_in = 4'h0;
  logic irq_pending_in = 0, ext_irq0_n_in = 1, ext_irq1_n_in = 1, ext_irq0_en_in = 0, ext_irq1_en_in = 0;
  logic ext_code_in = 0, ale_run_in = 0, program_store_strobe_n_run_in = 1, osc_stable_in;
  logic [7:0] port0_data_in = 8'h00, port1_data_in = 8'h00, port2_data_in = 8'h00, port3_data_in = 8'h00;
  logic [3:0] power_control_reg_out;
  logic cpu_clk_en_out, periph_clk_en_out, osc_en_out, cpu_hold_out, sfr_reset_out, ram_block_out;
  logic [15:0] reset_vector_out;
  logic [1:0] mode_out, last_mode = 2'h0;
  logic [7:0] port0_out, port0_oe_n_out, port1_out, port2_out, port3_out;
  logic ale_out, program_store_strobe_n_out, watch = 1;
  logic [1:0] note_q[$];
  int fail_count = 0, num_checks = 0, seed = 14457;
  pmc_power_mode_controller u_pmc_power_mode_controller (.clk_in, .rst_in, .reset_pin_in, .instr_done_in,
    .power_control_reg_we_in, .power_control_reg_wdata_in, .irq_pending_in, .ext_irq0_n_in, .ext_irq1_n_in, .ext_irq0_en_in,
    .ext_irq1_en_in, .ext_code_in, .osc_stable_in, .port0_data_in, .port1_data_in, .port2_data_in,
    .port3_data_in, .ale_run_in, .program_store_strobe_n_run_in, .power_control_reg_out, .cpu_clk_en_out,
    .periph_clk_en_out, .osc_en_out, .cpu_hold_out, .sfr_reset_out, .reset_vector_out, .ram_block_out,
    .mode_out, .port0_out, .port0_oe_n_out, .port1_out, .port2_out, .port3_out, .ale_out,
    .program_store_strobe_n_out);
  pmc_osc_model u_pmc_osc_model (.clk_in(clk_in), .osc_en_in(osc_en_out), .osc_stable_out(osc_stable_in));
  // ----------------------------------------
  // Clock, comparison and closing
  // ----------------------------------------
  initial begin
    forever #20 clk_in = ~clk_in;
  end
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // Inputs always move 1 ns after the rising edge
  task automatic step(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  // Write the control register, then complete the instruction
  // no port write follows entry
  task automatic enter(input logic [3:0] v, input logic [1:0] m);
    power_control_reg_we_in = 1;
    power_control_reg_wdata_in = v;
    step(1);
    power_control_reg_we_in = 0;
    note_q.push_back(m);
    instr_done_in = 1;
    step(1);
    instr_done_in = 0;
  endtask
  // Mode watcher: while watch is set, every change of mode takes the oldest note
  initial begin
    forever begin
      @(posedge clk_in);
      #2;
      if (!rst_in && watch && mode_out !== last_mode) begin
        if (note_q.size() > 0) check("mode", mode_out, note_q.pop_front());
        else check("unexpected mode", mode_out, last_mode);
      end
      last_mode = mode_out;
    end
  end
  // Hang guard, far beyond the few dozen cycles of the run
  initial begin
    #300000;
    fail_count++;
    test_done();
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    step(3);
    check("p0 float", port0_oe_n_out, 8'hFF);
    check("p123", {port1_out, port2_out, port3_out}, 24'hFFFFFF);
    check("strobes", {ale_out, program_store_strobe_n_out}, 2'h3);
    check("vector", reset_vector_out, 16'h0000);
    check("power_control_reg rst", power_control_reg_out, 4'h0);
    rst_in = 0;
    {port0_data_in, port1_data_in, port2_data_in, port3_data_in} = {$random(seed)};
    ext_code_in = 1;
    step(2);
    check("strobes run", {ale_out, program_store_strobe_n_out}, 2'h1);
    // Idle with a general flag set, from external code
    enter(4'h5, 2'h1);
    check("cpu clk idle", cpu_clk_en_out, 1'b0);
    check("per clk idle", periph_clk_en_out, 1'b1);
    check("hold idle", cpu_hold_out, 1'b1);
    check("strobes idle", {ale_out, program_store_strobe_n_out}, 2'h3);
    check("p0 ext idle", port0_oe_n_out, 8'hFF);
    check("p1 idle", port1_out, port1_data_in);
    power_control_reg_we_in = 1;
    power_control_reg_wdata_in = 4'hF;
    step(1);
    power_control_reg_we_in = 0;
    step(1);
    check("power_control_reg kept", power_control_reg_out, 4'h5);
    note_q.push_back(2'h0);
    irq_pending_in = 1;
    step(1);
    irq_pending_in = 0;
    step(1);
    check("power_control_reg idle exit", power_control_reg_out, 4'h4);
    check("cpu clk back", cpu_clk_en_out, 1'b1);
    // Both request bits, internal code: power-down only
    ext_code_in = 0;
    enter(4'hB, 2'h2);
    check("osc off", {osc_en_out, cpu_clk_en_out, periph_clk_en_out}, 3'h0);
    check("strobes pd", {ale_out, program_store_strobe_n_out}, 2'h0);
    check("p0 pd", {port0_oe_n_out, port0_out}, {8'h00, port0_data_in});
    ext_irq1_n_in = 0;
    step(5);
    check("masked wake", osc_en_out, 1'b0);
    ext_irq1_n_in = 1;
    ext_irq0_en_in = 1;
    note_q.push_back(2'h3);
    ext_irq0_n_in = 0;
    #1;
    check("osc wake", osc_en_out, 1'b1);
    // Pin held well past the oscillator start-up time
    // wake pin held long
    step(8);
    check("held", {mode_out, cpu_hold_out}, 3'h7);
    note_q.push_back(2'h0);
    ext_irq0_n_in = 1;
    for (int i = 0; i < 10 && mode_out !== 2'h0; i++) step(1);
    step(4);
    check("power_control_reg pd exit", power_control_reg_out, 4'h8);
    check("no idle fall", {mode_out, cpu_clk_en_out}, 3'h1);
    check("queue", note_q.size(), 32'h00000000);
    // Power-down left through the second wake input
    enter(4'h2, 2'h2);
    ext_irq1_en_in = 1;
    note_q.push_back(2'h3);
    ext_irq1_n_in = 0;
    step(8);
    check("held irq1", {mode_out, cpu_hold_out}, 3'h7);
    note_q.push_back(2'h0);
    ext_irq1_n_in = 1;
    for (int i = 0; i < 10 && mode_out !== 2'h0; i++) step(1);
    step(1);
    check("power_control_reg irq1 exit", power_control_reg_out, 4'h0);
    // Reset pin out of idle
    enter(4'h1, 2'h1);
    watch = 0;
    reset_pin_in = 1;
    #1;
    check("cpu clk pin", cpu_clk_en_out, 1'b1);
    for (int i = 0; i < 6 && ram_block_out !== 1'b1; i++) step(1);
    check("ram block", ram_block_out, 1'b1);
    check("power_control_reg pin", power_control_reg_out[1:0], 2'h0);
    for (int i = 0; i < 10 && sfr_reset_out !== 1'b1; i++) step(1);
    check("sfr reset", sfr_reset_out, 1'b1);
    rst_in = 1;
    step(2);
    reset_pin_in = 0;
    rst_in = 0;
    step(3);
    check("power_control_reg after", power_control_reg_out, 4'h0);
    check("ram after", ram_block_out, 1'b0);
    check("mode after", mode_out, 2'h0);
    test_done();
  end
endmodule
`default_nettype wire
